// ===== rtl/ufwd_ctrl.sv
// Function
// - unknown unicast enable set: use unknown unicast port map, else not
// - unicast map one bit per port; zero drops, all ones floods
// - unknown non-IP multicast enable set: use its port map, else not
// - multicast map one bit per port; zero drops, all ones floods
// - unknown VLAN ID enable set: use its port map, else not
// - VLAN ID map one bit per port; zero drops, all ones floods
// - unknown IP multicast enable set: use its port map, else not
// - IP multicast map one bit per port; zero drops, all ones floods
// - self filter bit 6 set drops frames to own address, else pass
// - self filter acts at egress against the programmed switch address
// - ingress rate period 00 16 ms, 01 64 ms, 1x 256 ms; reset 01
// - bit 3 clear limits egress per port, set per queue
// - tag select set: each egress uses its control 8 per source port
// - tag select clear: insertion follows source port control 0 bit 2
// - drive strength loads inverted strap high bit, strap low bit
`timescale 1ns/100ps
`include "ufwd_regs.svh"

module ufwd_ctrl import ufwd_pkg::*; #(
  parameter int unsigned P16_CYC = `UFWD_PERIOD_16_MS * `UFWD_CLK_KHZ,
  parameter int unsigned P64_CYC = `UFWD_PERIOD_64_MS * `UFWD_CLK_KHZ,
  parameter int unsigned P256_CYC = `UFWD_PERIOD_256_MS * `UFWD_CLK_KHZ
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic drive_strength_strap_pin,
  input wire logic [47:0] switch_mac_addr,
  input wire logic lk_valid,
  input wire logic [2:0] lk_class,
  input wire logic [4:0] lk_default_map,
  input wire logic [47:0] lk_dst_mac,
  input wire logic [2:0] lk_src_port,
  input wire logic [24:0] port_ctrl8_insert,
  input wire logic [4:0] port_ctrl0_insert,
  output logic fwd_valid,
  output logic [4:0] fwd_map,
  output logic fwd_drop,
  output logic [4:0] fwd_tag_insert,
  output logic [1:0] ingress_period_sel,
  output logic ingress_period_tick,
  output logic egress_queue_mode,
  output logic [1:0] drive_strength
);

  // ********************************************************************
  // register storage
  // ********************************************************************
  logic uc_en_ff, mc_en_ff, vid_en_ff, ipmc_en_ff, self_en_ff;
  logic queue_mode_ff, tag_sel_ff;
  ufwd_map_t uc_map_ff, mc_map_ff, vid_map_ff, ipmc_map_ff;
  logic [1:0] drive_ff, period_ff;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;

  wire wr_uc = reg_wr && reg_addr == `UFWD_UNK_UC_OFS;
  wire wr_mc = reg_wr && reg_addr == `UFWD_UNK_MC_OFS;
  wire wr_vid = reg_wr && reg_addr == `UFWD_UNK_VID_OFS;
  wire wr_ipmc = reg_wr && reg_addr == `UFWD_SELF_IPMC_OFS;
  wire wr_rate = reg_wr && reg_addr == `UFWD_RATE_TAG_OFS;
  wire [4:0] wmap = reg_wdata[`UFWD_MAP_MSB:`UFWD_MAP_LSB];
  wire wen = reg_wdata[`UFWD_FWD_EN_BIT];

  // ********************************************************************
  // strap capture
  // ********************************************************************
  logic strap_s1_ff, strap_s2_ff, strap_s3_ff;
  logic [1:0] strap_cnt_ff;
  logic strap_done_ff;
  // strap sampled after release; asynchronous reset only loads constants
  wire strap_load = !strap_done_ff && strap_cnt_ff == `UFWD_STRAP_WAIT &&
                    strap_s2_ff == strap_s3_ff;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      strap_s1_ff <= 1'b1;
      strap_s2_ff <= 1'b1;
      strap_s3_ff <= 1'b1;
      strap_cnt_ff <= 2'h0;
      strap_done_ff <= 1'b0;
    end else begin
      strap_s1_ff <= drive_strength_strap_pin;
      strap_s2_ff <= strap_s1_ff;
      strap_s3_ff <= strap_s2_ff;
      if (strap_cnt_ff != `UFWD_STRAP_WAIT) begin
        strap_cnt_ff <= strap_cnt_ff + 2'h1;
      end
      if (strap_load) begin
        strap_done_ff <= 1'b1;
      end
    end
  end

  // ********************************************************************
  // register writes
  // ********************************************************************
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      uc_en_ff <= `UFWD_EN_RST;
      uc_map_ff <= `UFWD_MAP_RST;
      mc_en_ff <= `UFWD_EN_RST;
      mc_map_ff <= `UFWD_MAP_RST;
      vid_en_ff <= `UFWD_EN_RST;
      vid_map_ff <= `UFWD_MAP_RST;
      ipmc_en_ff <= `UFWD_EN_RST;
      ipmc_map_ff <= `UFWD_MAP_RST;
      self_en_ff <= `UFWD_EN_RST;
      period_ff <= `UFWD_PERIOD_RST;
      queue_mode_ff <= `UFWD_EN_RST;
      tag_sel_ff <= `UFWD_EN_RST;
      drive_ff <= `UFWD_DRIVE_RST;
    end else begin
      if (wr_uc) begin
        uc_en_ff <= wen;
        uc_map_ff <= wmap;
      end
      if (wr_mc) begin
        mc_en_ff <= wen;
        mc_map_ff <= wmap;
        drive_ff <= reg_wdata[`UFWD_DRIVE_MSB:`UFWD_DRIVE_LSB];
      end else if (strap_load) begin
        drive_ff <= {~strap_s3_ff, strap_s3_ff};
      end
      if (wr_vid) begin
        vid_en_ff <= wen;
        vid_map_ff <= wmap;
      end
      if (wr_ipmc) begin
        ipmc_en_ff <= wen;
        ipmc_map_ff <= wmap;
        self_en_ff <= reg_wdata[`UFWD_SELF_EN_BIT];
      end
      if (wr_rate) begin
        period_ff <= reg_wdata[`UFWD_PERIOD_MSB:`UFWD_PERIOD_LSB];
        queue_mode_ff <= reg_wdata[`UFWD_QUEUE_MODE_BIT];
        tag_sel_ff <= reg_wdata[`UFWD_TAG_SEL_BIT];
      end
    end
  end

  // ********************************************************************
  // register reads
  // ********************************************************************
  // reserved bits are constants here, writes to them cannot stick
  always_comb begin
    case (reg_addr)
      `UFWD_UNK_UC_OFS: nxt_rdata = {`UFWD_UC_FIXED_VAL, 1'b0, uc_en_ff, uc_map_ff};
      `UFWD_UNK_MC_OFS: nxt_rdata = {drive_ff, mc_en_ff, mc_map_ff};
      `UFWD_UNK_VID_OFS: nxt_rdata = {2'h0, vid_en_ff, vid_map_ff};
      `UFWD_SELF_IPMC_OFS: nxt_rdata = {1'b0, self_en_ff, ipmc_en_ff, ipmc_map_ff};
      `UFWD_RATE_TAG_OFS: nxt_rdata = {2'h0, period_ff, queue_mode_ff, tag_sel_ff, 2'h0};
      default: nxt_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;

  // ********************************************************************
  // forwarding decision
  // ********************************************************************
  // map is used bit for bit: zero filters, all ones floods every port
  function automatic ufwd_map_t pick_map(input logic en, input ufwd_map_t map,
                                         input ufwd_map_t dflt);
    pick_map = en ? map : dflt;
  endfunction

  logic [4:0] class_map;
  always_comb begin
    case (lk_class)
      UFWD_UNK_UC: class_map = pick_map(uc_en_ff, uc_map_ff, lk_default_map);
      UFWD_UNK_MC: class_map = pick_map(mc_en_ff, mc_map_ff, lk_default_map);
      UFWD_UNK_VID: class_map = pick_map(vid_en_ff, vid_map_ff, lk_default_map);
      UFWD_UNK_IPMC: class_map = pick_map(ipmc_en_ff, ipmc_map_ff, lk_default_map);
      default: class_map = lk_default_map;
    endcase
  end

  // egress side drop of frames to our own address
  wire self_hit = self_en_ff && lk_dst_mac == switch_mac_addr;
  wire [4:0] final_map = self_hit ? 5'h00 : class_map;

  // tag insertion per egress port for the frame's source port
  logic [4:0] tag_vec;
  always_comb begin
    for (int e = 0; e < 5; e++) begin
      if (tag_sel_ff) begin
        tag_vec[e] = port_ctrl8_insert[e * 5 + int'(lk_src_port)];
      end else begin
        tag_vec[e] = port_ctrl0_insert[lk_src_port];
      end
    end
  end

  logic valid_ff, drop_ff;
  logic [4:0] map_ff, tag_ff;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      valid_ff <= 1'b0;
      map_ff <= 5'h00;
      drop_ff <= 1'b0;
      tag_ff <= 5'h00;
    end else begin
      valid_ff <= lk_valid;
      map_ff <= final_map;
      drop_ff <= final_map == 5'h00;
      tag_ff <= tag_vec;
    end
  end

  assign fwd_valid = valid_ff;
  assign fwd_map = map_ff;
  assign fwd_drop = drop_ff;
  assign fwd_tag_insert = tag_ff;
  assign ingress_period_sel = period_ff;
  assign egress_queue_mode = queue_mode_ff;
  assign drive_strength = drive_ff;

  // ********************************************************************
  // ingress period tick
  // ********************************************************************
  ufwd_period_tick #(
    .P16_CYC(P16_CYC),
    .P64_CYC(P64_CYC),
    .P256_CYC(P256_CYC)
  ) u_tick (
    .clock(clock),
    .rst_b(rst_b),
    .period_sel(period_ff),
    .period_tick(ingress_period_tick)
  );

  // ********************************************************************
  // checks
  // ********************************************************************
  sequence s_uc_lookup;
    lk_valid && lk_class == UFWD_UNK_UC && !self_hit;
  endsequence

  // write to the rate register, then a read of it on the next edge
  sequence s_rate_wr_rd;
    wr_rate ##1 reg_addr == `UFWD_RATE_TAG_OFS;
  endsequence

  a_uc_map_used: assert property (@(posedge clock) disable iff (!rst_b)
    s_uc_lookup ##0 uc_en_ff |=> fwd_map == $past(uc_map_ff))
    else $error("unicast map not applied");
  a_uc_map_off: assert property (@(posedge clock) disable iff (!rst_b)
    s_uc_lookup ##0 !uc_en_ff |=> fwd_map == $past(lk_default_map))
    else $error("unicast map applied while off");
  a_mc_map_used: assert property (@(posedge clock) disable iff (!rst_b)
    lk_class == UFWD_UNK_MC && mc_en_ff && !self_hit |=> fwd_map == $past(mc_map_ff))
    else $error("multicast map wrong");
  a_vid_map_used: assert property (@(posedge clock) disable iff (!rst_b)
    lk_class == UFWD_UNK_VID && vid_en_ff && !self_hit |=> fwd_map == $past(vid_map_ff))
    else $error("vlan map wrong");
  a_ipmc_map_used: assert property (@(posedge clock) disable iff (!rst_b)
    lk_class == UFWD_UNK_IPMC && ipmc_en_ff && !self_hit |=> fwd_map == $past(ipmc_map_ff))
    else $error("ip multicast map wrong");
  a_self_drop: assert property (@(posedge clock) disable iff (!rst_b)
    self_en_ff && lk_dst_mac == switch_mac_addr |=> fwd_drop && fwd_map == 5'h00)
    else $error("self frame not dropped");
  a_uc_fixed_bit: assert property (@(posedge clock) disable iff (!rst_b)
    reg_addr == `UFWD_UNK_UC_OFS |=> reg_rdata[7:6] == 2'b10)
    else $error("reserved bits wrong");
  a_write_effect: assert property (@(posedge clock) disable iff (!rst_b)
    s_rate_wr_rd |=> reg_rdata[5:2] == $past(reg_wdata[5:2], 2))
    else $error("write not visible");
  a_strap_load: assert property (@(posedge clock) disable iff (!rst_b)
    strap_load && !wr_mc |=> drive_strength == {~$past(strap_s3_ff), $past(strap_s3_ff)})
    else $error("strap not loaded");
  a_tag_ctrl0: assert property (@(posedge clock) disable iff (!rst_b)
    !tag_sel_ff && lk_src_port < 3'h5 |=> fwd_tag_insert == {5{$past(port_ctrl0_insert[lk_src_port])}})
    else $error("tag insertion wrong");
  a_tag_ctrl8: assert property (@(posedge clock) disable iff (!rst_b)
    tag_sel_ff && lk_src_port < 3'h5 |=> fwd_tag_insert == $past({
      port_ctrl8_insert[20 + int'(lk_src_port)], port_ctrl8_insert[15 + int'(lk_src_port)],
      port_ctrl8_insert[10 + int'(lk_src_port)], port_ctrl8_insert[5 + int'(lk_src_port)],
      port_ctrl8_insert[int'(lk_src_port)]}))
    else $error("control 8 tag insertion wrong");
  a_mc_map_off: assert property (@(posedge clock) disable iff (!rst_b)
    lk_class == UFWD_UNK_MC && !mc_en_ff && !self_hit |=> fwd_map == $past(lk_default_map))
    else $error("multicast map applied while off");
  a_vid_map_off: assert property (@(posedge clock) disable iff (!rst_b)
    lk_class == UFWD_UNK_VID && !vid_en_ff && !self_hit |=> fwd_map == $past(lk_default_map))
    else $error("vlan map applied while off");
  a_ipmc_map_off: assert property (@(posedge clock) disable iff (!rst_b)
    lk_class == UFWD_UNK_IPMC && !ipmc_en_ff && !self_hit |=> fwd_map == $past(lk_default_map))
    else $error("ip multicast map applied while off");
  a_uc_flood: assert property (@(posedge clock) disable iff (!rst_b)
    s_uc_lookup ##0 uc_en_ff && uc_map_ff == 5'h1F |=> fwd_map == 5'h1F && !fwd_drop)
    else $error("unicast flood wrong");
  a_queue_mode: assert property (@(posedge clock) disable iff (!rst_b)
    wr_rate |=> egress_queue_mode == $past(reg_wdata[`UFWD_QUEUE_MODE_BIT]))
    else $error("egress limit mode wrong");
  a_period_field: assert property (@(posedge clock) disable iff (!rst_b)
    wr_rate |=> ingress_period_sel == $past(reg_wdata[`UFWD_PERIOD_MSB:`UFWD_PERIOD_LSB]))
    else $error("period field wrong");

endmodule

// ===== rtl/ufwd_period_tick.sv
`timescale 1ns/100ps
`include "ufwd_regs.svh"

module ufwd_period_tick import ufwd_pkg::*; #(
  parameter int unsigned P16_CYC = `UFWD_PERIOD_16_MS * `UFWD_CLK_KHZ,
  parameter int unsigned P64_CYC = `UFWD_PERIOD_64_MS * `UFWD_CLK_KHZ,
  parameter int unsigned P256_CYC = `UFWD_PERIOD_256_MS * `UFWD_CLK_KHZ
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [1:0] period_sel,
  output logic period_tick
);

  logic [31:0] cnt_ff;
  logic [31:0] nxt_cnt;
  logic [1:0] sel_ff;
  logic tick_ff;
  logic [31:0] reload;
  logic restart;

  // ********************************************************************
  // unit period selection
  // ********************************************************************
  assign reload = (period_sel == UFWD_P16) ? 32'(P16_CYC - 1) :
                  (period_sel == UFWD_P64) ? 32'(P64_CYC - 1) :
                  32'(P256_CYC - 1);
  // a new period code restarts the count at once, no partial old unit
  assign restart = (sel_ff != period_sel);
  assign nxt_cnt = (restart || cnt_ff == 32'h0) ? reload : cnt_ff - 32'h1;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cnt_ff <= 32'(P64_CYC - 1);
      sel_ff <= `UFWD_PERIOD_RST;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      sel_ff <= period_sel;
      tick_ff <= !restart && cnt_ff == 32'h0;
    end
  end

  assign period_tick = tick_ff;

  a_tick_reload: assert property (@(posedge clock) disable iff (!rst_b)
    period_tick |-> $past(cnt_ff) == 32'h0) else $error("tick without expiry");

endmodule

// ===== rtl/ufwd_pkg.sv
package ufwd_pkg;

  typedef enum logic [2:0] {
    UFWD_KNOWN = 3'h0,
    UFWD_UNK_UC = 3'h1,
    UFWD_UNK_MC = 3'h2,
    UFWD_UNK_VID = 3'h3,
    UFWD_UNK_IPMC = 3'h4
  } ufwd_class_e;

  typedef enum logic [1:0] {
    UFWD_P16 = 2'h0,
    UFWD_P64 = 2'h1,
    UFWD_P256A = 2'h2,
    UFWD_P256B = 2'h3
  } ufwd_period_e;

  typedef logic [4:0] ufwd_map_t;

endpackage

// ===== rtl/ufwd_regs.svh
`ifndef UFWD_REGS_SVH
`define UFWD_REGS_SVH

// ********************************************************************
// register offsets
// ********************************************************************
`define UFWD_UNK_UC_OFS 8'h83
`define UFWD_UNK_MC_OFS 8'h84
`define UFWD_UNK_VID_OFS 8'h85
`define UFWD_SELF_IPMC_OFS 8'h86
`define UFWD_RATE_TAG_OFS 8'h87

// ********************************************************************
// field positions
// ********************************************************************
`define UFWD_MAP_MSB 4
`define UFWD_MAP_LSB 0
`define UFWD_FWD_EN_BIT 5
`define UFWD_SELF_EN_BIT 6
`define UFWD_DRIVE_MSB 7
`define UFWD_DRIVE_LSB 6
`define UFWD_PERIOD_MSB 5
`define UFWD_PERIOD_LSB 4
`define UFWD_QUEUE_MODE_BIT 3
`define UFWD_TAG_SEL_BIT 2
`define UFWD_UC_FIXED_BIT 7

// ********************************************************************
// reset values
// ********************************************************************
`define UFWD_MAP_RST 5'h00
`define UFWD_EN_RST 1'h0
`define UFWD_DRIVE_RST 2'h1
`define UFWD_PERIOD_RST 2'h1
`define UFWD_UC_FIXED_VAL 1'h1

// ********************************************************************
// timing
// ********************************************************************
`define UFWD_CLK_KHZ 200000
`define UFWD_PERIOD_16_MS 16
`define UFWD_PERIOD_64_MS 64
`define UFWD_PERIOD_256_MS 256
`define UFWD_STRAP_WAIT 2'h3

`endif

// ===== verification/ufwd_ctrl_bench.sv
`timescale 1ns/100ps
`include "ufwd_regs.svh"

module ufwd_ctrl_bench import ufwd_pkg::*;;
  // ****************
  // stimulus and dut
  // ****************
  localparam logic [47:0] OWN_MAC = 48'h021122334455;
  localparam logic [4:0] DFLT = 5'h0A;
  logic clock, rst_b, reg_wr, strap, lk_valid;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [47:0] dst;
  logic [2:0] cls, src;
  logic [4:0] fmap, tins, c0, last_tag;
  logic [24:0] c8;
  logic fvalid, fdrop, ptick, qmode;
  logic [1:0] psel, dstr;
  int err_total, num_checks;

  ufwd_ctrl #(.P16_CYC(8), .P64_CYC(16), .P256_CYC(32)) uut (
    .clock(clock), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .drive_strength_strap_pin(strap),
    .switch_mac_addr(OWN_MAC), .lk_valid(lk_valid), .lk_class(cls),
    .lk_default_map(DFLT), .lk_dst_mac(dst), .lk_src_port(src),
    .port_ctrl8_insert(c8), .port_ctrl0_insert(c0), .fwd_valid(fvalid),
    .fwd_map(fmap), .fwd_drop(fdrop), .fwd_tag_insert(tins),
    .ingress_period_sel(psel), .ingress_period_tick(ptick),
    .egress_queue_mode(qmode), .drive_strength(dstr));

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // ****************
  // shared tasks
  // ****************
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // bounded wait for the next period tick; running out ends the run
  task automatic wait_tick(output int n);
    n = 0;
    do begin
      @(posedge clock);
      #1 n++;
    end while (ptick !== 1'b1 && n < 100);
    if (n >= 100) begin
      err_total++;
      conclude();
    end
  endtask

  task automatic do_reset(input logic s);
    strap <= s;
    rst_b <= 1'b0;
    repeat (5) @(posedge clock);
    rst_b <= 1'b1;
    // strap passes a three-flop synchroniser before it loads
    repeat (10) @(posedge clock);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    @(posedge clock);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string nm);
    reg_addr <= a;
    repeat (2) @(posedge clock);
    #1 chk(nm, exp, reg_rdata);
    @(posedge clock);
  endtask

  task automatic lk(input logic [2:0] c, input logic [47:0] d, input logic [4:0] ex);
    cls <= c;
    dst <= d;
    lk_valid <= 1'b1;
    @(posedge clock);
    lk_valid <= 1'b0;
    #1 chk("fwd valid drop map", {1'b1, ex == 5'h00, ex}, {fvalid, fdrop, fmap});
    last_tag = tins;
    @(posedge clock);
  endtask

  // ****************
  // scenarios
  // ****************
  task automatic t_reset_vals(input logic s);
    rd(8'h83, 8'h80, "unicast reset");
    rd(8'h84, {~s, s, 6'h00}, "multicast reset");
    rd(8'h85, 8'h00, "vid reset");
    rd(8'h86, 8'h00, "ipmc reset");
    rd(8'h87, 8'h10, "rate reset");
    rd(8'h88, 8'h00, "unmapped reset");
    chk("outputs reset", {2'h1, 1'b0, ~s, s}, {psel, qmode, dstr});
  endtask

  task automatic t_reserved;
    logic [7:0] ex [6];
    ex = '{8'hBF, 8'hFF, 8'h3F, 8'h7F, 8'h3C, 8'h00};
    for (int i = 0; i < 6; i++) wr(8'h83 + i[7:0], 8'hFF);
    for (int i = 0; i < 6; i++) rd(8'h83 + i[7:0], ex[i], "reserved bits");
    chk("outputs all ones", {2'h3, 1'b1, 2'h3}, {psel, qmode, dstr});
  endtask

  task automatic t_forward;
    logic [4:0] maps [4];
    maps = '{5'h00, 5'h01, 5'h15, 5'h1F};
    for (int c = 1; c < 5; c++) begin
      for (int en = 0; en < 2; en++) begin
        for (int m = 0; m < 4; m++) begin
          wr(8'h82 + c[7:0], {2'b00, en[0], maps[m]});
          lk(c[2:0], 48'h0, en ? maps[m] : DFLT);
        end
      end
    end
    // distinct maps catch one class reading another class's register
    for (int c = 1; c < 5; c++) wr(8'h82 + c[7:0], 8'h20 | (8'h01 << (c - 1)));
    for (int c = 1; c < 5; c++) lk(c[2:0], 48'h0, 5'h01 << (c - 1));
    lk(3'h0, 48'h0, DFLT);
  endtask

  task automatic t_self;
    wr(8'h86, 8'h40);
    lk(3'h0, OWN_MAC, 5'h00);
    lk(3'h0, OWN_MAC ^ 48'h800000000000, DFLT);
    lk(3'h0, OWN_MAC ^ 48'h000000000001, DFLT);
    lk(3'h1, OWN_MAC, 5'h00);
    wr(8'h86, 8'h00);
    lk(3'h0, OWN_MAC, DFLT);
  endtask

  task automatic t_tag;
    logic [4:0] ex;
    wr(8'h87, 8'h10);
    for (int s = 0; s < 5; s++) begin
      src <= s[2:0];
      lk(3'h0, 48'h0, DFLT);
      chk("tag from control 0", {5{c0[s]}}, last_tag);
    end
    wr(8'h87, 8'h14);
    for (int s = 0; s < 5; s++) begin
      src <= s[2:0];
      for (int e = 0; e < 5; e++) ex[e] = c8[e * 5 + s];
      lk(3'h0, 48'h0, DFLT);
      chk("tag from control 8", ex, last_tag);
    end
  endtask

  task automatic t_period;
    int cnt;
    int per [4];
    per = '{8, 16, 32, 32};
    for (int p = 0; p < 4; p++) begin
      wr(8'h87, {2'b00, p[1:0], 4'h8});
      chk("period and mode", {p[1:0], 1'b1}, {psel, qmode});
      // first tick follows the restart, the second one gives the interval
      wait_tick(cnt);
      wait_tick(cnt);
      chk("tick interval", per[p], cnt);
      @(posedge clock);
    end
    wr(8'h87, 8'h10);
    chk("port based mode", 1'b0, qmode);
  endtask

  initial begin
    rst_b = 1'b0;
    strap = 1'b1;
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    lk_valid = 1'b0;
    cls = 3'h0;
    dst = 48'h0;
    src = 3'h0;
    c8 = 25'h1B3A5C6;
    c0 = 5'h0A;
    err_total = 0;
    num_checks = 0;
    do_reset(1'b1);
    t_reset_vals(1'b1);
    t_reserved();
    t_forward();
    t_self();
    t_tag();
    t_period();
    do_reset(1'b0);
    t_reset_vals(1'b0);
    conclude();
  end
endmodule
